// ===== shared/tsp_pkg.sv
// Constants and types shared by both ends of the temperature sensor serial port.
//
// How it works
// RL1 - Port has select, clock, data in, data out.
// RL2 - Read-only host may hold data input low.
// RL3 - Device is slave; host drives serial clock.
// RL4 - Frame reads result, writes control register.
// RL5 - Clock edges ignored while select is high.
// RL6 - Frame is sixteen clock pulses, ten data.
// RL7 - Last bit held until select rises, then released.
// RL8 - Data input sampled on every rising edge.
// RL9 - Third bit in is shutdown; one sleeps.
// RL10 - Host drives all non-shutdown bits as zero.
// RL11 - Control latched on fifteenth falling edge.
// RL12 - Early deselect discards partial control word.
// RL13 - Result shifted out most significant first.
// RL14 - Frame may be two byte transfers.
// RL15 - Host clock idles high between transfers.
// RL16 - Two's complement quarter degree result encoding.
// RL17 - Result held in read-only ten-bit register.
// RL18 - Data output changes after each falling edge.
// RL19 - Shutdown stops conversions, keeps last result.
// RL20 - Bit counter restarts whenever select asserts.
package tsp_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;          // Clock pulses per frame.
  localparam int unsigned DATA_BITS  = 10;          // Temperature bits per frame.
  localparam int unsigned BYTE_BITS  = 8;           // Bits per half frame.
  localparam logic [4:0]  LATCH_FALL = 5'h0_00F;    // Falling edge that loads control.
  localparam int unsigned PD_IDX     = 11;          // Third bit in, after 14 shifts.
  localparam int unsigned PD_TX_IDX  = 13;          // Third bit out of the host word.

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [9:0]  RESULT_RST = 10'h0_000;   // Zero degrees.
  localparam logic [15:0] CTRL_RST   = 16'h0_000;   // Normal operation.

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 40;      // System clock period.
  localparam int unsigned SCLK_PERIOD_NS = 320;     // Serial clock period made by the host.
  localparam int unsigned HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0]  HALF_LAST = 4'(HALF_CYC - 1);  // Last count of a half period.
  localparam logic [3:0]  GAP_LAST  = 4'(2 * HALF_CYC - 1); // Pause between bytes.

  // ---------------------------------------------------------------
  // Host register map (byte addresses on Avalon-MM)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;         // W: go, shutdown, split.
  localparam logic [3:0] REG_STATUS = 4'h4;         // R: busy, done.
  localparam logic [3:0] REG_RESULT = 4'h8;         // R: result and raw frame.
  localparam int unsigned CTRL_GO    = 0;
  localparam int unsigned CTRL_PD    = 1;
  localparam int unsigned CTRL_SPLIT = 2;
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_DONE  = 1;

  // Device end states.
  typedef enum logic [1:0] {
    TSPD_IDLE   = 2'b00,
    TSPD_ACTIVE = 2'b01,
    TSPD_DONE   = 2'b11
  } tsp_dev_state_t;

  // Host end states.
  typedef enum logic [2:0] {
    TSPH_IDLE  = 3'b000,
    TSPH_SETUP = 3'b001,
    TSPH_LOW   = 3'b011,
    TSPH_HIGH  = 3'b010,
    TSPH_HOLD  = 3'b110,
    TSPH_GAP   = 3'b111
  } tsp_host_state_t;

endpackage

// ===== shared/tsp_if.sv
// Four-wire serial link between the sensor port and its host.
`timescale 1ns/1ps
`default_nettype none
interface tsp_if;
  logic cs_n;        // Select, active low, from the host.
  logic sclk;        // Serial clock from the host, idles high.
  logic din;         // Data into the device.
  logic dout;        // Data out of the device.
  logic dout_oe_n;   // Low while the device drives its data output.
  logic dout_line;   // Resolved line level; a pull-up holds it high when released.

  assign dout_line = dout_oe_n ? 1'b1 : dout;

  modport dev  (input cs_n, input sclk, input din, output dout, output dout_oe_n);
  modport host (output cs_n, output sclk, output din, input dout_line);
endinterface
`default_nettype wire

// ===== hw/tsp_dev.sv
// Device end of the temperature sensor serial port.
`timescale 1ns/1ps
`default_nettype none
module tsp_dev
  import tsp_pkg::*;
(
  input  wire logic        clk_i,           // System clock.
  input  wire logic        sys_rst_i,       // Synchronous reset, active high.
  tsp_if.dev               link,            // Serial pins.
  input  wire logic [9:0]  result_i,        // New conversion result.
  input  wire logic        result_valid_i,  // Strobe for result_i.
  output logic             shutdown_o,      // High while in shutdown.
  output logic             conv_en_o,       // Converter may start conversions.
  output logic [15:0]      control_word_o   // Last latched control word.
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_s;       // Select chain; only bit 1 is read.
  logic [1:0] sclk_s;     // Clock chain; only bit 1 is read.
  logic [1:0] din_s;      // Data chain; only bit 1 is read.
  logic       cs_d;       // Delayed select for the assert edge.
  logic       sclk_d;     // Delayed clock for edge detection.

  // Every pin passes two flip-flops before any logic reads it.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs_s   <= 2'b11;
      sclk_s <= 2'b11;
      din_s  <= 2'b00;
      cs_d   <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      cs_s   <= {cs_s[0], link.cs_n};
      sclk_s <= {sclk_s[0], link.sclk};
      din_s  <= {din_s[0], link.din};
      cs_d   <= cs_s[1];
      sclk_d <= sclk_s[1];
    end
  end

  // ---------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------
  logic sel;       // Device is selected.
  logic sel_go;    // First cycle of selection.
  logic rise;      // Rising serial clock edge while selected.
  logic fall;      // Falling serial clock edge while selected.

  // Edges only count while select is low, so a clock toggled for
  // another device on the same wires leaves this one alone.
  always_comb begin
    sel    = ~cs_s[1];
    sel_go = sel & cs_d;
    rise   = sel & ~cs_d & sclk_s[1] & ~sclk_d;   // [RL5] [RL3]
    fall   = sel & ~cs_d & ~sclk_s[1] & sclk_d;   // [RL5] [RL3]
  end

  // ---------------------------------------------------------------
  // Result register
  // ---------------------------------------------------------------
  logic [9:0] temp_r;    // Latest result, not writable over the link.
  logic [9:0] temp_nxt;
  logic       pd_r;      // Shutdown state.
  logic       pd_nxt;
  logic       conv_r;    // Conversion enable output.
  logic       conv_nxt;

  // New results are only taken while running, so shutdown keeps the
  // last result from before it.
  always_comb begin
    temp_nxt = temp_r;
    conv_nxt = ~pd_nxt;                             // [RL19]
    if (result_valid_i && !pd_r) begin
      temp_nxt = result_i;                          // [RL17] [RL19] [RL16]
    end
  end

  // ---------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------
  tsp_dev_state_t state_r;    // Frame state.
  tsp_dev_state_t state_nxt;
  logic [4:0]  cnt_r;         // Falling edges seen in this frame.
  logic [4:0]  cnt_nxt;
  logic [9:0]  out_sh_r;      // Result bits still to send.
  logic [9:0]  out_sh_nxt;
  logic [15:0] in_sh_r;       // Control bits shifted in.
  logic [15:0] in_sh_nxt;
  logic [15:0] ctrl_r;        // Latched control word.
  logic [15:0] ctrl_nxt;
  logic        dout_r;        // Data output level.
  logic        dout_nxt;
  logic        oe_n_r;        // Data output enable, active low.
  logic        oe_n_nxt;

  // Computes the next frame state from the detected edges.
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    out_sh_nxt = out_sh_r;
    in_sh_nxt  = in_sh_r;
    ctrl_nxt   = ctrl_r;
    pd_nxt     = pd_r;
    dout_nxt   = dout_r;
    oe_n_nxt   = oe_n_r;
    if (!sel) begin
      // Deselected: release the line and drop any partial word.
      state_nxt = TSPD_IDLE;                        // [RL12]
      oe_n_nxt  = 1'b1;                             // [RL7]
    end else if (sel_go) begin
      // New frame: count from zero and snapshot the result.
      state_nxt  = TSPD_ACTIVE;
      cnt_nxt    = 5'h0_000;                        // [RL20]
      out_sh_nxt = temp_r;                          // [RL4]
      in_sh_nxt  = 16'h0_000;
      dout_nxt   = 1'b0;
      oe_n_nxt   = 1'b0;
    end else begin
      if (rise) begin
        // Control bits arrive on rising edges, alongside the read.
        in_sh_nxt = {in_sh_r[14:0], din_s[1]};      // [RL8] [RL4]
      end
      if (fall) begin
        if (cnt_r != 5'(FRAME_BITS)) begin
          cnt_nxt = cnt_r + 5'h0_001;               // [RL6]
        end
        if (cnt_r < 5'(DATA_BITS)) begin
          // Next bit goes out after the falling edge, top bit first.
          dout_nxt   = out_sh_r[9];                 // [RL18] [RL13]
          out_sh_nxt = {out_sh_r[8:0], 1'b0};
        end
        // Past the last data bit dout_nxt keeps its level.   [RL7]
        if (state_r == TSPD_ACTIVE && cnt_r == LATCH_FALL - 5'h0_001) begin
          // Only fourteen rising edges precede the fifteenth fall, so the
          // word holds fourteen bits; the word and shutdown take effect now.
          ctrl_nxt  = {in_sh_r[13:0], 2'b00};       // [RL11]
          pd_nxt    = in_sh_r[PD_IDX];              // [RL9] [RL11]
          state_nxt = TSPD_DONE;
        end
      end
    end
  end

  // Registers the frame engine and the result.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r  <= TSPD_IDLE;
      cnt_r    <= 5'h0_000;
      out_sh_r <= RESULT_RST;
      in_sh_r  <= 16'h0_000;
      ctrl_r   <= CTRL_RST;
      pd_r     <= 1'b0;
      dout_r   <= 1'b0;
      oe_n_r   <= 1'b1;
      temp_r   <= RESULT_RST;
      conv_r   <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      out_sh_r <= out_sh_nxt;
      in_sh_r  <= in_sh_nxt;
      ctrl_r   <= ctrl_nxt;
      pd_r     <= pd_nxt;
      dout_r   <= dout_nxt;
      oe_n_r   <= oe_n_nxt;
      temp_r   <= temp_nxt;
      conv_r   <= conv_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // All outputs come straight from flip-flops.
  assign link.dout      = dout_r;                   // [RL1]
  assign link.dout_oe_n = oe_n_r;                   // [RL1]
  assign shutdown_o     = pd_r;
  assign conv_en_o      = conv_r;
  assign control_word_o = ctrl_r;

endmodule
`default_nettype wire

// ===== hw/tsp_host.sv
// Host end of the temperature sensor serial port, steered over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module tsp_host
  import tsp_pkg::*;
(
  input  wire logic        clk_i,              // System clock.
  input  wire logic        sys_rst_i,          // Synchronous reset, active high.
  input  wire logic [3:0]  avs_address_i,      // Byte address.
  input  wire logic        avs_read_i,         // Read request.
  input  wire logic        avs_write_i,        // Write request.
  input  wire logic [31:0] avs_writedata_i,    // Write data.
  input  wire logic [3:0]  avs_byteenable_i,   // Byte lanes.
  output logic [31:0]      avs_readdata_o,     // Read data.
  output logic             avs_waitrequest_o,  // Low for the cycle that completes.
  tsp_if.host              link                // Serial pins.
);

  // ---------------------------------------------------------------
  // Avalon slave
  // ---------------------------------------------------------------
  logic        wait_r;     // Waitrequest, high until the answer cycle.
  logic        wait_nxt;
  logic [31:0] rdata_r;    // Read data.
  logic [31:0] rdata_nxt;
  logic        acc;        // Request completes at this edge.
  logic        go;         // Start a frame.
  logic        done_clr;   // Clear the done flag.
  logic        pd_r;       // Shutdown bit to send.
  logic        split_r;    // Send the frame as two bytes.
  logic        done_r;     // Frame finished, sticky.
  logic [9:0]  temp_r;     // Last received result.
  logic [15:0] raw_r;      // Last received frame.
  logic        busy;

  // Every access answers one cycle after it is first seen.
  always_comb begin
    acc       = (avs_read_i | avs_write_i) & ~wait_r;
    wait_nxt  = ~((avs_read_i | avs_write_i) & wait_r);
    rdata_nxt = rdata_r;
    go        = acc & avs_write_i & avs_byteenable_i[0] & (avs_address_i == REG_CTRL)
                & avs_writedata_i[CTRL_GO];
    done_clr  = acc & avs_write_i & avs_byteenable_i[0] & (avs_address_i == REG_STATUS)
                & avs_writedata_i[STAT_DONE];
    if (avs_read_i && wait_r) begin
      unique case (avs_address_i)
        REG_CTRL:   rdata_nxt = {29'h0000_0000, split_r, pd_r, 1'b0};
        REG_STATUS: rdata_nxt = {30'h0000_0000, done_r, busy};
        REG_RESULT: rdata_nxt = {raw_r, 6'h00, temp_r};
        default:    rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------
  tsp_host_state_t state_r;
  tsp_host_state_t state_nxt;
  logic [3:0]  div_r;        // Half period counter.
  logic [3:0]  div_nxt;
  logic [4:0]  bit_r;        // Bits completed.
  logic [4:0]  bit_nxt;
  logic [15:0] tx_r;         // Word to send.
  logic [15:0] tx_nxt;
  logic [15:0] rx_r;         // Word received.
  logic [15:0] rx_nxt;
  logic        cs_n_r, cs_n_nxt;
  logic        sclk_r, sclk_nxt;
  logic        din_r, din_nxt;
  logic        pd_nxt, split_nxt, done_nxt;
  logic [9:0]  temp_nxt;
  logic [15:0] raw_nxt;
  logic [1:0]  dout_s;       // Data line synchroniser; bit 1 is read.

  // Walks select, clock and data through one sixteen-bit frame.
  always_comb begin
    busy      = (state_r != TSPH_IDLE);
    state_nxt = state_r;
    div_nxt   = div_r - 4'h1;
    bit_nxt   = bit_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    cs_n_nxt  = cs_n_r;
    sclk_nxt  = sclk_r;
    din_nxt   = din_r;
    pd_nxt    = pd_r;
    split_nxt = split_r;
    done_nxt  = done_r & ~done_clr;
    temp_nxt  = temp_r;
    raw_nxt   = raw_r;
    unique case (state_r)
      TSPH_IDLE: begin
        div_nxt  = HALF_LAST;
        sclk_nxt = 1'b1;                              // [RL15]
        if (go) begin
          // Only the shutdown bit may be one.
          pd_nxt    = avs_writedata_i[CTRL_PD];
          split_nxt = avs_writedata_i[CTRL_SPLIT];
          tx_nxt    = 16'h0_000;                      // [RL10] [RL2]
          tx_nxt[PD_TX_IDX] = avs_writedata_i[CTRL_PD]; // [RL9]
          bit_nxt   = 5'h0_000;
          cs_n_nxt  = 1'b0;
          state_nxt = TSPH_SETUP;
        end
      end
      TSPH_SETUP, TSPH_GAP: begin
        if (div_r == 4'h0) begin
          sclk_nxt  = 1'b0;                           // [RL3]
          din_nxt   = tx_r[15];
          tx_nxt    = {tx_r[14:0], 1'b0};
          div_nxt   = HALF_LAST;
          state_nxt = TSPH_LOW;
        end
      end
      TSPH_LOW: begin
        if (div_r == 4'h0) begin
          sclk_nxt  = 1'b1;
          div_nxt   = HALF_LAST;
          state_nxt = TSPH_HIGH;
        end
      end
      TSPH_HIGH: begin
        if (div_r == 4'h0) begin
          // Sample late in the high phase, well after the rising edge.
          rx_nxt  = {rx_r[14:0], dout_s[1]};          // [RL13]
          bit_nxt = bit_r + 5'h0_001;
          if (bit_r == 5'(FRAME_BITS - 1)) begin
            div_nxt   = HALF_LAST;
            state_nxt = TSPH_HOLD;                    // [RL6]
          end else if (split_r && bit_r == 5'(BYTE_BITS - 1)) begin
            div_nxt   = GAP_LAST;                     // [RL14]
            state_nxt = TSPH_GAP;
          end else begin
            sclk_nxt  = 1'b0;
            din_nxt   = tx_r[15];
            tx_nxt    = {tx_r[14:0], 1'b0};
            div_nxt   = HALF_LAST;
            state_nxt = TSPH_LOW;
          end
        end
      end
      TSPH_HOLD: begin
        if (div_r == 4'h0) begin
          cs_n_nxt  = 1'b1;
          din_nxt   = 1'b0;
          raw_nxt   = rx_r;
          temp_nxt  = rx_r[15:6];
          done_nxt  = 1'b1;
          state_nxt = TSPH_IDLE;
        end
      end
      default: state_nxt = TSPH_IDLE;
    endcase
  end

  // Registers the slave, the engine and the line synchroniser.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      state_r <= TSPH_IDLE;
      div_r   <= 4'h0;
      bit_r   <= 5'h0_000;
      tx_r    <= 16'h0_000;
      rx_r    <= 16'h0_000;
      cs_n_r  <= 1'b1;
      sclk_r  <= 1'b1;
      din_r   <= 1'b0;
      pd_r    <= 1'b0;
      split_r <= 1'b0;
      done_r  <= 1'b0;
      temp_r  <= RESULT_RST;
      raw_r   <= 16'h0_000;
      dout_s  <= 2'b11;
    end else begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      div_r   <= div_nxt;
      bit_r   <= bit_nxt;
      tx_r    <= tx_nxt;
      rx_r    <= rx_nxt;
      cs_n_r  <= cs_n_nxt;
      sclk_r  <= sclk_nxt;
      din_r   <= din_nxt;
      pd_r    <= pd_nxt;
      split_r <= split_nxt;
      done_r  <= done_nxt;
      temp_r  <= temp_nxt;
      raw_r   <= raw_nxt;
      dout_s  <= {dout_s[0], link.dout_line};
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o    = rdata_r;
  assign link.cs_n         = cs_n_r;
  assign link.sclk         = sclk_r;
  assign link.din          = din_r;

endmodule
`default_nettype wire

// ===== dv/tsp_monitor.sv
// Concurrent checks on the four-wire link between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module tsp_monitor (
  input wire logic clk_i,      // System clock.
  input wire logic sys_rst_i,  // Synchronous reset, active high.
  input wire logic cs_n,       // Select, active low.
  input wire logic sclk,       // Serial clock from the host.
  input wire logic din,        // Data into the device.
  input wire logic dout,       // Data out of the device.
  input wire logic dout_oe_n   // Low while the device drives data out.
);
  // ---------------------------------------------------------------
  // Falling edge counter
  // ---------------------------------------------------------------
  logic       sclk_r;    // Serial clock one cycle back.
  logic [4:0] fall_r;    // Falls seen in the current frame.
  logic [4:0] fall_nxt;  // Next value of the fall count.

  // Counts falls while selected; a deselect clears it for the next frame.
  always_comb begin
    fall_nxt = fall_r;
    if (cs_n) begin
      fall_nxt = 5'h00;
    end else if (sclk_r && !sclk) begin
      fall_nxt = fall_r + 5'h01;
    end
  end

  // Registers the count and the delayed clock.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sclk_r <= 1'b1;
      fall_r <= 5'h00;
    end else begin
      sclk_r <= sclk;
      fall_r <= fall_nxt;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ---------------------------------------------------------------
  // Link checks
  // ---------------------------------------------------------------
  a_frame_setup: assert property ($fell(cs_n) |-> sclk [*4] ##1 !sclk)
    else $error("Serial clock did not start four cycles after select.");
  a_low_phase: assert property (!cs_n && $fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("Serial clock low phase has the wrong length.");
  a_pulse_count: assert property ($rose(cs_n) |-> fall_r == 5'h10)
    else $error("Frame did not hold sixteen clock pulses.");
  a_out_after_fall: assert property (!cs_n && fall_r != 5'h00 && sclk && $past(sclk)
    |-> $stable(dout))
    else $error("Data out changed during the high phase.");
  a_last_bit_held: assert property (!cs_n && $past(fall_r) > 5'h0A |-> $stable(dout))
    else $error("Data out moved after the last data bit.");
  a_driven_in_frame: assert property (!cs_n && fall_r != 5'h00 |-> !dout_oe_n)
    else $error("Data out not driven inside the frame.");
  a_release_soon: assert property ($rose(cs_n) |-> ##[1:5] dout_oe_n)
    else $error("Data out not released after deselect.");
  a_stay_released: assert property (cs_n [*6] |-> dout_oe_n)
    else $error("Data out driven while deselected.");
  a_din_on_fall: assert property (!cs_n && $changed(din) |-> $fell(sclk))
    else $error("Data in changed away from a falling edge.");
  a_clock_idle: assert property (cs_n [*2] |-> sclk)
    else $error("Serial clock not idle high between frames.");
endmodule
`default_nettype wire

// ===== dv/temp_sensor_serial_port_test.sv
// Self-checking bench joining the host and device ends of the sensor port.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_serial_port_test;
  import tsp_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk_i;      // System clock.
  logic        sys_rst_i;  // Synchronous reset.
  logic [3:0]  av_addr;    // Avalon address.
  logic        av_rd;      // Avalon read.
  logic        av_wr;      // Avalon write.
  logic [31:0] av_wdata;   // Avalon write data.
  logic [31:0] av_rdata;   // Avalon read data.
  logic        av_wait;    // Avalon waitrequest.
  logic [31:0] q;          // Data of the last read.
  logic [9:0]  res;        // Result fed to both device ends.
  logic        res_vld;    // Strobe for the result.
  logic        sd;         // Shutdown of the main device.
  logic        sd_b;       // Shutdown of the bit-banged device.
  logic        conv_en;    // Conversion enable of the main device.
  logic [15:0] cw;         // Control word of the main device.
  logic [15:0] cw_b;       // Control word of the bit-banged device.
  int          err_count;  // Mismatches.
  int          checked;    // Comparisons.
  int          cyc;        // Cycles run, for the watchdog.
  logic [9:0]  enc [5] = '{10'h1F4, 10'h3FF, 10'h001, 10'h200, 10'h2AA}; // Results.
  tsp_if       link();     // Link between host and device.
  tsp_if       link_b();   // Link driven by the bench.

  tsp_host tsp_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(av_addr),
    .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
    .avs_byteenable_i(4'hF), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
    .link(link));
  tsp_dev tsp_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link), .result_i(res),
    .result_valid_i(res_vld), .shutdown_o(sd), .conv_en_o(conv_en), .control_word_o(cw));
  // The second device faces the bench, which can break the host's rules.
  tsp_dev tsp_dev_b_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link_b), .result_i(res),
    .result_valid_i(res_vld), .shutdown_o(sd_b), .conv_en_o(), .control_word_o(cw_b));
  tsp_monitor tsp_monitor_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .dout(link.dout), .dout_oe_n(link.dout_oe_n));

  // Clock generator.
  initial begin
    clk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  end

  // Watchdog: a hang counts as a mismatch.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Compares a seen value against the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is low.
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    av_addr <= a;
    av_wr <= wr;
    av_rd <= !wr;
    av_wdata <= d;
    @(posedge clk_i);
    while (av_wait !== 1'b0) @(posedge clk_i);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk_i);
  endtask

  // Runs one host frame, waits for done and clears it.
  task automatic frame(input logic [31:0] ctrl);
    av(1'b1, REG_CTRL, ctrl | 32'h0000_0001);
    q = 32'h0000_0000;
    while (q[STAT_DONE] !== 1'b1) av(1'b0, REG_STATUS, 32'h0000_0000);
    av(1'b1, REG_STATUS, 32'h0000_0002);
  endtask

  // Offers a new conversion result to both devices.
  task automatic put(input logic [9:0] v);
    res <= v;
    res_vld <= 1'b1;
    @(posedge clk_i);
    res_vld <= 1'b0;
    @(posedge clk_i);
  endtask

  // Bit-banged frame of n pulses; sel low leaves select high throughout.
  task automatic bang(input logic [15:0] w, input int n, input logic sel);
    link_b.cs_n <= !sel;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      link_b.sclk <= 1'b0;
      link_b.din <= w[15-i];
      repeat (4) @(posedge clk_i);
      link_b.sclk <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    link_b.cs_n <= 1'b1;
    link_b.din <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {err_count, checked, cyc} = '0;
    {av_addr, av_rd, av_wr, av_wdata, res, res_vld} = '0;
    sys_rst_i = 1'b1;
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b1;
    link_b.din = 1'b0;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    // Each result read MSB first, last bit held; odd ones as two bytes.
    foreach (enc[i]) begin
      put(enc[i]);
      frame((i % 2) ? 32'h0000_0004 : 32'h0000_0000);
      av(1'b0, REG_RESULT, 32'h0000_0000);
      check(q, {enc[i], {6{enc[i][0]}}, 6'h00, enc[i]});
    end
    av(1'b0, REG_STATUS, 32'h0000_0000);
    check(q, 32'h0000_0000);
    av(1'b1, 4'hC, 32'hFFFF_FFFF);
    av(1'b0, 4'hC, 32'h0000_0000);
    check(q, 32'h0000_0000);
    // Shutdown through the third bit, result frozen meanwhile.
    frame(32'h0000_0002);
    check({31'h0, sd}, 32'h0000_0001);
    check({31'h0, conv_en}, 32'h0000_0000);
    check({16'h0, cw}, 32'h0000_2000);
    av(1'b0, REG_CTRL, 32'h0000_0000);
    check(q, 32'h0000_0002);
    put(10'h155);
    frame(32'h0000_0002);
    av(1'b0, REG_RESULT, 32'h0000_0000);
    check({22'h0, q[9:0]}, 32'h0000_02AA);
    frame(32'h0000_0000);
    check({31'h0, sd}, 32'h0000_0000);
    check({16'h0, cw}, 32'h0000_0000);
    // Rule-breaking host on the second link.
    bang(16'h2000, 14, 1'b1);
    check({31'h0, sd_b}, 32'h0000_0000);
    bang(16'h2000, 15, 1'b1);
    check({31'h0, sd_b}, 32'h0000_0001);
    check({16'h0, cw_b}, 32'h0000_2000);
    bang(16'h0000, 16, 1'b0);
    check({31'h0, sd_b}, 32'h0000_0001);
    bang(16'h0000, 15, 1'b1);
    check({31'h0, sd_b}, 32'h0000_0000);
    check({31'h0, link_b.dout_oe_n}, 32'h0000_0001);
    wrap_up();
  end
endmodule
`default_nettype wire
